// ==== shared/cfs_pkg.sv ====
// constants and types shared by the core special function register set
package cfs_pkg;
    // special function register addresses
    localparam logic [7:0] ADDR_PRIO_LOW = 8'hB8;
    localparam logic [7:0] ADDR_STATUS = 8'hD0;
    localparam logic [7:0] ADDR_MAIN_OP = 8'hE0;
    localparam logic [7:0] ADDR_SECOND_OP = 8'hF0;
    localparam logic [7:0] ADDR_PRIO_HIGH = 8'hF8;

    // reset values
    localparam logic [7:0] RST_PRIO_LOW = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_MAIN_OP = 8'h00;
    localparam logic [7:0] RST_SECOND_OP = 8'h00;
    localparam logic [7:0] RST_PRIO_HIGH = 8'h00;

    // writable bits of the low priority group; bits 7 and 6 read as zero
    localparam logic [7:0] PRIO_LOW_MASK = 8'h3F;
    localparam int PRIO_LOW_BITS = 6;

    // processor status word field positions
    localparam int CARRY_BIT = 7;
    localparam int AUX_CARRY_BIT = 6;
    localparam int USER_FLAG_ZERO_BIT = 5;
    localparam int BANK_SELECT_HIGH_BIT = 4;
    localparam int BANK_SELECT_LOW_BIT = 3;
    localparam int SIGNED_EXCESS_BIT = 2;
    localparam int USER_FLAG_ONE_BIT = 1;
    localparam int ODD_ONES_BIT = 0;

    // working register bank: eight registers per bank
    localparam int BANK_SHIFT = 3;

    // interrupt sources, index order is also the polling order
    localparam int NUM_SOURCES = 14;
    localparam int SOURCE_IDX_W = 4;

    // interrupt nesting state, one-hot
    typedef enum logic [3:0] {
        NEST_IDLE = 4'h1,   // no routine running
        NEST_LOW = 4'h2,    // a low level routine running
        NEST_HIGH = 4'h4,   // a high level routine running alone
        NEST_BOTH = 4'h8    // a high level routine pre-empted a low one
    } cfs_nest_type;
endpackage

// ==== shared/cfs_arb_if.sv ====
// signals between the register set and its interrupt priority arbiter
`timescale 1ns/1ps
interface cfs_arb_if;
    logic [cfs_pkg::NUM_SOURCES-1:0] pend;    // enabled and pending requests
    logic [cfs_pkg::NUM_SOURCES-1:0] prio;    // one means high level
    logic allow_high;                         // a high level request may start
    logic allow_low;                          // a low level request may start
    logic hit;                                // some request may start now
    logic [cfs_pkg::SOURCE_IDX_W-1:0] idx;    // winning source
    logic lvl;                                // level of the winning source

    modport arb (input pend, input prio, input allow_high, input allow_low,
                 output hit, output idx, output lvl);
    modport core (output pend, output prio, output allow_high, output allow_low,
                  input hit, input idx, input lvl);
endinterface

// ==== verilog/cfs_prio_arb.sv ====
// fixed order interrupt priority arbiter
`timescale 1ns/1ps
module cfs_prio_arb (
    // link to the register set
    cfs_arb_if.arb arb
);
    // requests split by level
    logic [cfs_pkg::NUM_SOURCES-1:0] high_req;
    logic [cfs_pkg::NUM_SOURCES-1:0] low_req;

    // only levels that the nesting state allows may compete
    assign high_req = arb.allow_high ? (arb.pend & arb.prio) : '0;
    assign low_req = arb.allow_low ? (arb.pend & ~arb.prio) : '0;

    // high level first, then the lowest index within a level
    always_comb begin
        arb.hit = 1'b0;
        arb.idx = '0;
        arb.lvl = 1'b0;
        // scan downward so the lowest index is the last to claim
        for (int i = cfs_pkg::NUM_SOURCES - 1; i >= 0; i--) begin
            if (low_req[i] && !(|high_req)) begin
                arb.hit = 1'b1;
                arb.idx = cfs_pkg::SOURCE_IDX_W'(i);
                arb.lvl = 1'b0;
            end
        end
        for (int i = cfs_pkg::NUM_SOURCES - 1; i >= 0; i--) begin
            if (high_req[i]) begin
                arb.hit = 1'b1;
                arb.idx = cfs_pkg::SOURCE_IDX_W'(i);
                arb.lvl = 1'b1;
            end
        end
    end
endmodule // cfs_prio_arb

// ==== verilog/cfs_core_sfr.sv ====
// processor core special function registers with interrupt priority control
`timescale 1ns/1ps
module cfs_core_sfr (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,

    // special function register access
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,

    // alu results
    input wire logic alu_flags_we,
    input wire logic alu_carry,
    input wire logic alu_aux_carry,
    input wire logic alu_signed_excess,
    input wire logic alu_acc_we,
    input wire logic [7:0] alu_acc_data,
    input wire logic muldiv_second_we,
    input wire logic [7:0] muldiv_second_data,

    // operands and status toward the datapath
    output logic [7:0] main_operand,
    output logic [7:0] second_operand,
    output logic [7:0] status_word,
    input wire logic [2:0] work_reg_sel,
    output logic [7:0] work_reg_addr,

    // interrupt sources and enables
    input wire logic [cfs_pkg::NUM_SOURCES-1:0] irq_pending,
    input wire logic [cfs_pkg::NUM_SOURCES-1:0] irq_enable,
    input wire logic global_interrupt_gate,

    // interrupt sequencing with the core
    input wire logic irq_window,
    output logic irq_take,
    output logic [cfs_pkg::SOURCE_IDX_W-1:0] irq_source,
    output logic irq_level,
    input wire logic irq_return
);
    // reset synchroniser: first stage is read only by the second
    logic rst_meta;
    logic rst_n;

    // registers
    logic [7:0] prio_low;       // interrupt_priority_low_group
    logic [7:0] prio_high;      // interrupt_priority_high_group
    logic [7:0] processor_status_word;            // processor_status_word without parity
    logic odd_ones;             // parity of the accumulator
    logic [7:0] acc;            // main_operand_reg
    logic [7:0] breg;           // second_operand_reg
    logic [7:0] rdata;
    logic rhit;

    // next values
    logic [7:0] next_prio_low;
    logic [7:0] next_prio_high;
    logic [7:0] next_psw;
    logic next_odd_ones;
    logic [7:0] next_acc;
    logic [7:0] next_breg;
    logic [7:0] next_rdata;
    logic next_rhit;

    // interrupt nesting state and grant outputs
    // source and level hold between grants; only take is a pulse
    cfs_pkg::cfs_nest_type nest;
    cfs_pkg::cfs_nest_type next_nest;
    logic take;
    logic next_take;
    logic [cfs_pkg::SOURCE_IDX_W-1:0] src;
    logic [cfs_pkg::SOURCE_IDX_W-1:0] next_src;
    logic lvl;
    logic next_lvl;

    // address decode strobes
    // one strobe per register keeps the precedence logic below flat
    logic wr_prio_low;
    logic wr_prio_high;
    logic wr_status;
    logic wr_acc;
    logic wr_breg;

    // status word as software and the datapath see it
    logic [7:0] psw_view;

    // arbiter link
    cfs_arb_if arb_link ();

    // hazard: a raw release could reach flops on both sides of one edge
    // release reset through two flops so every register leaves reset together
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // byte write decode
    // unmapped addresses raise no strobe, so such writes simply vanish
    assign wr_prio_low = sfr_wr && (sfr_addr == cfs_pkg::ADDR_PRIO_LOW);
    assign wr_prio_high = sfr_wr && (sfr_addr == cfs_pkg::ADDR_PRIO_HIGH);
    assign wr_status = sfr_wr && (sfr_addr == cfs_pkg::ADDR_STATUS);
    assign wr_acc = sfr_wr && (sfr_addr == cfs_pkg::ADDR_MAIN_OP);
    assign wr_breg = sfr_wr && (sfr_addr == cfs_pkg::ADDR_SECOND_OP);

    // parity bit is spliced in from its own flop
    // limitation: software can never force the parity bit; a store to it is dropped
    always_comb begin
        psw_view = processor_status_word;
        psw_view[cfs_pkg::ODD_ONES_BIT] = odd_ones;
    end

    // next values of the register group
    always_comb begin
        next_prio_low = prio_low;
        next_prio_high = prio_high;
        next_psw = processor_status_word;
        next_acc = acc;
        next_breg = breg;
        // priority groups: reserved bits of the low group stay zero
        if (wr_prio_low) begin
            next_prio_low = sfr_wdata & cfs_pkg::PRIO_LOW_MASK;
        end
        if (wr_prio_high) begin
            next_prio_high = sfr_wdata;
        end
        // alu flags land first so an explicit store to the word overrides them
        if (alu_flags_we) begin
            next_psw[cfs_pkg::CARRY_BIT] = alu_carry;
            next_psw[cfs_pkg::AUX_CARRY_BIT] = alu_aux_carry;
            next_psw[cfs_pkg::SIGNED_EXCESS_BIT] = alu_signed_excess;
        end
        // user flags and bank bits change only here, never by hardware
        if (wr_status) begin
            next_psw = sfr_wdata;
        end
        // the parity position is never stored; it is always derived
        next_psw[cfs_pkg::ODD_ONES_BIT] = 1'b0;
        // accumulator: datapath result, then a direct register store
        if (alu_acc_we) begin
            next_acc = alu_acc_data;
        end
        if (wr_acc) begin
            next_acc = sfr_wdata;
        end
        // second operand: multiply/divide result, then a scratch pad store that overrides it
        if (muldiv_second_we) begin
            next_breg = muldiv_second_data;
        end
        if (wr_breg) begin
            next_breg = sfr_wdata;
        end
        // parity follows the value the accumulator takes at this edge,
        // so it never lags the accumulator by a cycle
        next_odd_ones = ^next_acc;
    end

    // register read: one cycle latency, unmapped addresses answer zero
    always_comb begin
        next_rdata = 8'h00;
        next_rhit = 1'b0;
        if (sfr_rd) begin
            next_rhit = 1'b1;
            unique case (sfr_addr)
                cfs_pkg::ADDR_PRIO_LOW: next_rdata = prio_low;
                cfs_pkg::ADDR_PRIO_HIGH: next_rdata = prio_high;
                cfs_pkg::ADDR_STATUS: next_rdata = psw_view;
                cfs_pkg::ADDR_MAIN_OP: next_rdata = acc;
                cfs_pkg::ADDR_SECOND_OP: next_rdata = breg;
                default: next_rhit = 1'b0; // not in this register set
            endcase
        end
    end

    // register the group
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prio_low <= cfs_pkg::RST_PRIO_LOW;
            prio_high <= cfs_pkg::RST_PRIO_HIGH;
            processor_status_word <= cfs_pkg::RST_STATUS;
            odd_ones <= 1'b0;
            acc <= cfs_pkg::RST_MAIN_OP;
            breg <= cfs_pkg::RST_SECOND_OP;
            rdata <= 8'h00;
            rhit <= 1'b0;
        end else begin
            prio_low <= next_prio_low;
            prio_high <= next_prio_high;
            processor_status_word <= next_psw;
            odd_ones <= next_odd_ones;
            acc <= next_acc;
            breg <= next_breg;
            rdata <= next_rdata;
            rhit <= next_rhit;
        end
    end

    // feed the arbiter: disabled sources and a closed gate never compete
    assign arb_link.pend = global_interrupt_gate ? (irq_pending & irq_enable) : '0;
    // sources 0..5 from the low group, 6..13 from the high group
    assign arb_link.prio = {prio_high, prio_low[cfs_pkg::PRIO_LOW_BITS-1:0]};
    // trade-off: two levels need only a four state nest, not a full stack
    // a high routine blocks everything; a low routine blocks equal level
    assign arb_link.allow_high = irq_window && (nest inside {cfs_pkg::NEST_IDLE,
                                                            cfs_pkg::NEST_LOW});
    assign arb_link.allow_low = irq_window && (nest == cfs_pkg::NEST_IDLE);

    // fixed order arbiter
    cfs_prio_arb u_arb (
        .arb(arb_link)
    );

    // nesting state: a grant pushes a level, a return pops the newest one
    always_comb begin
        next_nest = nest;
        next_take = 1'b0;
        next_src = src;
        next_lvl = lvl;
        unique case (nest)
            cfs_pkg::NEST_IDLE: begin
                // a stray return here blocks the grant, so the state must hold too
                if (arb_link.hit && !irq_return) begin
                    next_nest = arb_link.lvl ? cfs_pkg::NEST_HIGH : cfs_pkg::NEST_LOW;
                end
            end
            cfs_pkg::NEST_LOW: begin
                // a return wins over a fresh grant in the same cycle
                if (irq_return) begin
                    next_nest = cfs_pkg::NEST_IDLE;
                end else if (arb_link.hit) begin
                    next_nest = cfs_pkg::NEST_BOTH;
                end
            end
            cfs_pkg::NEST_HIGH: begin
                if (irq_return) begin
                    next_nest = cfs_pkg::NEST_IDLE;
                end
            end
            cfs_pkg::NEST_BOTH: begin
                if (irq_return) begin
                    next_nest = cfs_pkg::NEST_LOW;
                end
            end
            default: next_nest = cfs_pkg::NEST_IDLE; // recover from a bad code
        endcase
        // grant pulse only when the state really advanced on a request
        if (arb_link.hit && !irq_return) begin
            next_take = 1'b1;
            next_src = arb_link.idx;
            next_lvl = arb_link.lvl;
        end
    end

    // register the nesting state and the grant
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nest <= cfs_pkg::NEST_IDLE;
            take <= 1'b0;
            src <= '0;
            lvl <= 1'b0;
        end else begin
            nest <= next_nest;
            take <= next_take;
            src <= next_src;
            lvl <= next_lvl;
        end
    end

    // outputs
    // read data and hit come from flops and stand for one cycle
    assign sfr_rdata = rdata;
    assign sfr_hit = rhit;
    assign main_operand = acc;
    assign second_operand = breg;
    assign status_word = psw_view;
    // bank base is the two select bits times eight, plus the register number
    assign work_reg_addr = {3'h0, processor_status_word[cfs_pkg::BANK_SELECT_HIGH_BIT],
                            processor_status_word[cfs_pkg::BANK_SELECT_LOW_BIT], work_reg_sel};
    assign irq_take = take;
    assign irq_source = src;
    assign irq_level = lvl;
endmodule // cfs_core_sfr

// ==== test/cfs_core_sfr_monitor.sv ====
// concurrent checks on the ports of the core special function register set
`timescale 1ns/1ps
module cfs_core_sfr_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    // alu and datapath
    input wire logic alu_flags_we,
    input wire logic alu_carry,
    input wire logic alu_aux_carry,
    input wire logic alu_signed_excess,
    input wire logic muldiv_second_we,
    input wire logic [7:0] muldiv_second_data,
    input wire logic [7:0] main_operand,
    input wire logic [7:0] second_operand,
    input wire logic [7:0] status_word,
    input wire logic [2:0] work_reg_sel,
    input wire logic [7:0] work_reg_addr,
    // interrupt sequencing
    input wire logic global_interrupt_gate,
    input wire logic irq_window,
    input wire logic irq_take,
    input wire logic irq_level,
    input wire logic irq_return
);
    logic hi_run; // a high level routine is running
    logic lo_run; // a low level routine is running
    logic next_hi_run;
    logic next_lo_run;
    logic mapped; // address names one of the five registers
    logic wr_status; // software write to the status word this cycle
    assign mapped = sfr_addr inside {cfs_pkg::ADDR_PRIO_LOW, cfs_pkg::ADDR_STATUS,
        cfs_pkg::ADDR_MAIN_OP, cfs_pkg::ADDR_SECOND_OP, cfs_pkg::ADDR_PRIO_HIGH};
    assign wr_status = sfr_wr && sfr_addr == cfs_pkg::ADDR_STATUS;
    // nesting follows grants and returns seen at the ports only
    always_comb begin
        next_hi_run = hi_run;
        next_lo_run = lo_run;
        if (irq_return) begin
            // a return pops the newest level
            if (hi_run) next_hi_run = 1'b0;
            else next_lo_run = 1'b0;
        end else if (irq_take) begin
            if (irq_level) next_hi_run = 1'b1;
            else next_lo_run = 1'b1;
        end
    end
    // register the nesting picture
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hi_run <= 1'b0;
            lo_run <= 1'b0;
        end else begin
            hi_run <= next_hi_run;
            lo_run <= next_lo_run;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_mapped_hit: assert property (sfr_rd && mapped |=> sfr_hit)
        else $error("mapped read gave no hit");
    chk_unmapped_zero: assert property (sfr_rd && !mapped |=> sfr_rdata == 8'h00 && !sfr_hit)
        else $error("unmapped read gave data or hit");
    chk_low_upper_zero: assert property (sfr_rd && sfr_addr == cfs_pkg::ADDR_PRIO_LOW |=> sfr_rdata[7:6] == 2'b00)
        else $error("upper low group bits not zero");
    chk_parity_track: assert property (status_word[0] == ^main_operand)
        else $error("odd ones flag off");
    chk_bank_map: assert property (work_reg_addr == {3'b000, status_word[4:3], work_reg_sel})
        else $error("working register address wrong");
    chk_acc_write: assert property (sfr_wr && sfr_addr == cfs_pkg::ADDR_MAIN_OP |=> main_operand == $past(sfr_wdata))
        else $error("accumulator write lost");
    chk_second_load: assert property (muldiv_second_we && !(sfr_wr && sfr_addr == cfs_pkg::ADDR_SECOND_OP)
        |=> second_operand == $past(muldiv_second_data))
        else $error("second operand load lost");
    chk_alu_flags: assert property (alu_flags_we && !wr_status |=> status_word[7] == $past(alu_carry)
        && status_word[6] == $past(alu_aux_carry) && status_word[2] == $past(alu_signed_excess))
        else $error("alu flags not loaded");
    chk_user_flags: assert property (!wr_status |=> $stable(status_word[5]) && $stable(status_word[1]))
        else $error("user flag changed by hardware");
    chk_gate_needed: assert property (irq_take |-> $past(global_interrupt_gate) && $past(irq_window))
        else $error("grant without gate or window");
    chk_high_blocks: assert property (hi_run |-> !irq_take)
        else $error("grant while high routine runs");
    chk_low_preempt: assert property (lo_run && irq_take |-> irq_level)
        else $error("low grant pre-empted low routine");
    // main scenarios reached
    cov_preempt: cover property (lo_run && irq_take && irq_level);
    cov_unmapped: cover property (sfr_rd && !mapped);
    cov_alu: cover property (alu_flags_we && !wr_status);
endmodule // cfs_core_sfr_monitor

// ==== test/test_cfs_core_sfr.sv ====
// self-checking testbench for the core special function register set
`timescale 1ns/1ps
module test_cfs_core_sfr;
    logic clk, resetn, sfr_wr, sfr_rd, sfr_hit, alu_flags_we, alu_carry, alu_aux_carry;
    logic alu_signed_excess, alu_acc_we, muldiv_second_we, global_interrupt_gate;
    logic irq_window, irq_take, irq_level, irq_return, rd_d;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, alu_acc_data, muldiv_second_data;
    logic [7:0] main_operand, second_operand, status_word, work_reg_addr, a, sw, r;
    logic [2:0] work_reg_sel;
    logic [3:0] irq_source;
    logic [cfs_pkg::NUM_SOURCES-1:0] irq_pending, irq_enable;
    logic [8:0] rq[$]; // expected {hit, data} of reads in flight
    logic [4:0] gq[$]; // expected {level, source} of grants
    int err_count, n_checks;
    cfs_core_sfr DUT (.clk, .resetn, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata,
        .sfr_hit, .alu_flags_we, .alu_carry, .alu_aux_carry, .alu_signed_excess, .alu_acc_we,
        .alu_acc_data, .muldiv_second_we, .muldiv_second_data, .main_operand, .second_operand,
        .status_word, .work_reg_sel, .work_reg_addr, .irq_pending, .irq_enable,
        .global_interrupt_gate, .irq_window, .irq_take, .irq_source, .irq_level, .irq_return);
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check_byte(input string nm, input logic [8:0] e, input logic [8:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_grant(input string nm, input logic [4:0] e, input logic [4:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic print_verdict;
        if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // one write; the strobe covers exactly one rising edge
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = ad;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask
    // one read; the result watcher compares one cycle later
    task automatic rd(input logic [7:0] ad, input logic [8:0] e);
        @(negedge clk);
        sfr_addr = ad;
        sfr_rd = 1'b1;
        rq.push_back(e);
        @(negedge clk);
        sfr_rd = 1'b0;
    endtask
    // wait a bounded time for a grant, then withdraw that request
    task automatic grant(input logic [3:0] src, input logic lvl);
        gq.push_back({lvl, src});
        for (int i = 0; i < 8 && irq_take !== 1'b1; i++) @(negedge clk);
        check_grant("grant seen", 5'h01, {4'h0, irq_take});
        irq_pending[src] = 1'b0;
    endtask
    task automatic ret;
        @(negedge clk);
        irq_return = 1'b1;
        @(negedge clk);
        irq_return = 1'b0;
    endtask
    // result watcher: reads one cycle after the strobe, grants whenever they show
    always @(posedge clk) rd_d <= sfr_rd;
    always @(negedge clk) begin
        if (rd_d === 1'b1) check_byte("read", rq.pop_front(), {sfr_hit, sfr_rdata});
        // a grant nobody asked for meets an impossible source and fails
        if (irq_take === 1'b1) check_grant("grant", gq.size() ? gq.pop_front() : 5'h1F,
            {irq_level, irq_source});
    end
    // watchdog, far beyond the hundred or so cycles the tests need
    initial begin
        #20000;
        err_count++;
        print_verdict();
    end
    initial begin
        {sfr_wr, sfr_rd, alu_flags_we, alu_acc_we, muldiv_second_we, irq_return} = 6'h00;
        {alu_carry, alu_aux_carry, alu_signed_excess, global_interrupt_gate} = 4'h0;
        {sfr_addr, sfr_wdata, alu_acc_data, muldiv_second_data} = 32'h0000_0000;
        work_reg_sel = 3'h0;
        irq_pending = '0;
        irq_enable = '1;
        irq_window = 1'b1;
        resetn = 1'b0;
        err_count = 0;
        n_checks = 0;
        r = 8'($urandom(32'hCF46));
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        // reset values, then an unmapped place
        rd(cfs_pkg::ADDR_PRIO_LOW, 9'h100);
        rd(cfs_pkg::ADDR_STATUS, 9'h100);
        rd(cfs_pkg::ADDR_MAIN_OP, 9'h100);
        rd(cfs_pkg::ADDR_SECOND_OP, 9'h100);
        rd(cfs_pkg::ADDR_PRIO_HIGH, 9'h100);
        rd(8'h99, 9'h000);
        // random contents; the stored parity bit ignores software
        a = 8'($urandom());
        sw = 8'($urandom());
        r = 8'($urandom());
        wr(cfs_pkg::ADDR_MAIN_OP, a);
        wr(cfs_pkg::ADDR_STATUS, sw);
        wr(cfs_pkg::ADDR_SECOND_OP, r);
        wr(8'h99, ~r);
        wr(cfs_pkg::ADDR_PRIO_LOW, 8'hFF);
        wr(cfs_pkg::ADDR_PRIO_HIGH, ~r);
        rd(cfs_pkg::ADDR_MAIN_OP, {1'b1, a});
        rd(cfs_pkg::ADDR_STATUS, {1'b1, sw[7:1], ^a});
        rd(cfs_pkg::ADDR_SECOND_OP, {1'b1, r});
        rd(8'h99, 9'h000);
        rd(cfs_pkg::ADDR_PRIO_LOW, 9'h13F);
        rd(cfs_pkg::ADDR_PRIO_HIGH, {1'b1, ~r});
        // every bank: base is eight times the bank number
        for (int bk = 0; bk < 4; bk++) begin
            wr(cfs_pkg::ADDR_STATUS, {3'b000, 2'(bk), 3'b000});
            work_reg_sel = 3'($urandom());
            #1 check_byte("bank", 9'(bk * 8 + work_reg_sel), {1'b0, work_reg_addr});
        end
        // alu loads with both parities; user flags must survive
        wr(cfs_pkg::ADDR_STATUS, 8'h22);
        for (int k = 0; k < 2; k++) begin
            a = 8'($urandom());
            a[0] = ^a[7:1] ^ k[0];
            r = 8'($urandom());
            @(negedge clk);
            {alu_carry, alu_aux_carry, alu_signed_excess} = 3'($urandom());
            alu_acc_data = a;
            muldiv_second_data = r;
            alu_flags_we = 1'b1;
            alu_acc_we = 1'b1;
            muldiv_second_we = 1'b1;
            @(negedge clk);
            alu_flags_we = 1'b0;
            alu_acc_we = 1'b0;
            muldiv_second_we = 1'b0;
            check_byte("second", {1'b0, r}, {1'b0, second_operand});
            rd(cfs_pkg::ADDR_STATUS, {1'b1, alu_carry, alu_aux_carry, 3'b100, alu_signed_excess,
                1'b1, k[0]});
        end
        // serial port high in the low group, ext13 and ext6 high in the high group
        wr(cfs_pkg::ADDR_PRIO_LOW, 8'h10);
        wr(cfs_pkg::ADDR_PRIO_HIGH, 8'h81);
        irq_pending = 14'h0049;
        repeat (6) @(negedge clk); // gate closed: nothing may be granted
        irq_window = 1'b0;
        global_interrupt_gate = 1'b1;
        irq_enable = 14'h3FBF;
        repeat (4) @(negedge clk); // window closed: core not ready, nothing granted
        irq_window = 1'b1;
        grant(4'd0, 1'b0); // ext6 disabled, ext0 polled before timer1
        repeat (4) @(negedge clk); // equal level waits
        irq_enable = '1;
        grant(4'd6, 1'b1); // high pre-empts low
        irq_pending = irq_pending | 14'h2010;
        repeat (4) @(negedge clk); // high running blocks high
        ret();
        grant(4'd4, 1'b1); // lowest index first among the high level requests
        ret();
        grant(4'd13, 1'b1);
        ret();
        ret();
        grant(4'd3, 1'b0); // low waits until idle
        ret();
        repeat (4) @(negedge clk);
        print_verdict();
    end
endmodule // test_cfs_core_sfr
bind cfs_core_sfr cfs_core_sfr_monitor u_mon (.clk, .resetn, .sfr_addr, .sfr_wr, .sfr_wdata,
    .sfr_rd, .sfr_rdata, .sfr_hit, .alu_flags_we, .alu_carry, .alu_aux_carry, .alu_signed_excess,
    .muldiv_second_we, .muldiv_second_data, .main_operand, .second_operand, .status_word,
    .work_reg_sel, .work_reg_addr, .global_interrupt_gate, .irq_window, .irq_take, .irq_level,
    .irq_return);
